// ---- common/serial_port_pkg.sv ----
// Constants, codes and frame layout for the serial port with flow control
// and end-of-line terminators.
// Assumes a single clock domain; the baud divisor is derived in the core.
package serial_port_pkg;

    // Clock and divisor counter width.
    localparam int CLK_HZ_DEFAULT = 100_000_000;
    localparam int DIV_W          = 17;

    // Line rates in baud.
    localparam int BAUD_1200  = 1200;
    localparam int BAUD_2400  = 2400;
    localparam int BAUD_4800  = 4800;
    localparam int BAUD_9600  = 9600;
    localparam int BAUD_19200 = 19200;
    localparam int BAUD_38400 = 38400;

    // Rate select codes.
    localparam logic [2:0] RATE_1200  = 3'h0;
    localparam logic [2:0] RATE_2400  = 3'h1;
    localparam logic [2:0] RATE_4800  = 3'h2;
    localparam logic [2:0] RATE_9600  = 3'h3;
    localparam logic [2:0] RATE_19200 = 3'h4;
    localparam logic [2:0] RATE_38400 = 3'h5;

    // Outgoing terminator select codes.
    localparam logic [1:0] EOL_CR                = 2'h0;
    localparam logic [1:0] EOL_LF                = 2'h1;
    localparam logic [1:0] CR_THEN_LF_TERMINATOR = 2'h2;
    localparam logic [1:0] LF_THEN_CR_TERMINATOR = 2'h3;

    // Characters still to send for a terminator.
    localparam logic [1:0] EOL_NONE   = 2'h0;
    localparam logic [1:0] EOL_SINGLE = 2'h1;
    localparam logic [1:0] EOL_PAIR   = 2'h2;

    // Terminator characters.
    localparam logic [7:0] CHAR_CR = 8'h0D;
    localparam logic [7:0] CHAR_LF = 8'h0A;

    // Last received terminator, used to swallow the second of a pair.
    localparam logic [1:0] TERM_NONE = 2'h0;
    localparam logic [1:0] TERM_CR   = 2'h1;
    localparam logic [1:0] TERM_LF   = 2'h2;

    // Frame bit positions: start, eight data bits, stop.
    localparam logic [3:0] START_BIT = 4'h0;
    localparam logic [3:0] STOP_BIT  = 4'h9;

    // Defaults after reset and on the preset command.
    localparam logic [2:0] DEFAULT_RATE = RATE_9600;
    localparam logic       DEFAULT_FLOW = 1'b1;
    localparam logic [1:0] DEFAULT_EOL  = EOL_LF;

    typedef enum logic {TX_IDLE, TX_FRAME} tx_state_t;
    typedef enum logic {RX_IDLE, RX_FRAME} rx_state_t;

    // Terminator character to send, given the selection and how many remain.
    function automatic logic [7:0] eol_char(input logic [1:0] sel, input logic [1:0] left);
        logic [7:0] c;
        c = CHAR_LF;
        unique case (sel)
            EOL_CR:                c = CHAR_CR;
            EOL_LF:                c = CHAR_LF;
            CR_THEN_LF_TERMINATOR: c = (left == EOL_PAIR) ? CHAR_CR : CHAR_LF;
            LF_THEN_CR_TERMINATOR: c = (left == EOL_PAIR) ? CHAR_LF : CHAR_CR;
        endcase
        return c;
    endfunction : eol_char

endpackage : serial_port_pkg

// ---- core/serial_port_flow_terminator.sv ----
// Serial port core: 8N1 transmitter and receiver, request-to-send and
// clear-to-send flow control, and end-of-line terminator handling.
// Assumes a command parser and message queues; serial pins are asynchronous.
`timescale 1ns/100ps

// Summary of operation
// - Line rate selectable among six rates from 1200 to 38400 baud, reported on query.
// - With flow control on, a character starts only while clear-to-send is asserted.
// - With flow control on, request-to-send is asserted while receive queue has room.
// - Request-to-send stays low while the queue is full, then reasserts.
// - Nonzero argument enables flow control; zero disables it, request-to-send stays high.
// - Preset sets 9600 baud, flow control on and line feed terminator.
// - Four outgoing terminators: CR, LF, CR then LF, LF then CR.
// - The selected terminator follows the last character of every outgoing message.
// - Any of the four terminator forms ends a received message.
// - The second character of a received pair is an empty command, dropped.
// - Carriage return is 0x0D and line feed is 0x0A.
// - The settings query returns rate, terminator and flow state together.
module serial_port_flow_terminator
    import serial_port_pkg::*;
#(
    parameter int CLK_HZ = CLK_HZ_DEFAULT
) (
    // Clock, reset and clock enable.
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    input  wire logic       clk_en,
    // Settings commands.
    input  wire logic       rate_write,
    input  wire logic [2:0] rate_arg,
    input  wire logic       flow_write,
    input  wire logic [7:0] flow_arg,
    input  wire logic       eol_write,
    input  wire logic [1:0] eol_arg,
    input  wire logic       serial_defaults_restore,
    input  wire logic       serial_settings_query,
    // Settings answer.
    output logic            settings_valid,
    output logic      [2:0] settings_rate,
    output logic      [1:0] settings_eol,
    output logic            settings_flow,
    // Outgoing message bytes.
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_valid,
    input  wire logic       tx_last,
    output logic            tx_ready,
    // Incoming message bytes.
    output logic      [7:0] rx_data,
    output logic            rx_valid,
    output logic            rx_eom,
    input  wire logic       rx_queue_full,
    // Serial pins.
    output logic            serial_tx,
    input  wire logic       serial_rx,
    output logic            rts,
    input  wire logic       cts
);

    if (CLK_HZ / BAUD_1200 >= (1 << DIV_W) || CLK_HZ / BAUD_38400 < 4) begin : g_bad_clock
        $error("CLK_HZ does not fit the baud divisor counter");
    end

    typedef struct packed {
        logic [2:0]       serial_rate_select;
        logic             hw_flow_control_enable;
        logic [1:0]       outgoing_eol_select;
        logic             settings_valid;
        logic [2:0]       settings_rate;
        logic [1:0]       settings_eol;
        logic             settings_flow;
        logic [2:0]       cts_sync;
        logic             cts_ok;
        logic [2:0]       rx_sync;
        logic             rx_level;
        logic             rts;
        tx_state_t        tx_st;
        logic [DIV_W-1:0] tx_cnt;
        logic [3:0]       tx_bit;
        logic [9:0]       tx_shift;
        logic             serial_tx;
        logic             tx_ready;
        logic [1:0]       eol_left;
        rx_state_t        rx_st;
        logic [DIV_W-1:0] rx_cnt;
        logic [3:0]       rx_bit;
        logic [7:0]       rx_shift;
        logic [7:0]       rx_data;
        logic             rx_valid;
        logic             rx_eom;
        logic [1:0]       last_term;
    } state_t;

    localparam state_t RESET_STATE = '{
        serial_rate_select:     DEFAULT_RATE,
        hw_flow_control_enable: DEFAULT_FLOW,
        outgoing_eol_select:    DEFAULT_EOL,
        rx_sync:                3'h7,
        rx_level:               1'b1,
        rts:                    1'b1,
        tx_st:                  TX_IDLE,
        rx_st:                  RX_IDLE,
        serial_tx:              1'b1,
        default:                '0
    };

    state_t q;
    state_t next_q;

    // Divisor per rate code; codes six and seven are never stored but read as 9600.
    localparam logic [DIV_W-1:0] DIV_TABLE [8] = '{
        DIV_W'(CLK_HZ / BAUD_1200), DIV_W'(CLK_HZ / BAUD_2400), DIV_W'(CLK_HZ / BAUD_4800),
        DIV_W'(CLK_HZ / BAUD_9600), DIV_W'(CLK_HZ / BAUD_19200), DIV_W'(CLK_HZ / BAUD_38400),
        DIV_W'(CLK_HZ / BAUD_9600), DIV_W'(CLK_HZ / BAUD_9600)
    };

    always_comb begin
        logic [DIV_W-1:0] div;
        logic             go, is_cr, is_lf;
        div    = DIV_TABLE[q.serial_rate_select];
        go     = q.cts_ok || !q.hw_flow_control_enable;
        is_cr  = (q.rx_shift == CHAR_CR);
        is_lf  = (q.rx_shift == CHAR_LF);
        next_q = q;
        next_q.settings_valid = 1'b0;
        next_q.rx_valid       = 1'b0;

        // Preset wins over any setting written in the same cycle.
        if (serial_defaults_restore) begin
            next_q.serial_rate_select     = DEFAULT_RATE;
            next_q.hw_flow_control_enable = DEFAULT_FLOW;
            next_q.outgoing_eol_select    = DEFAULT_EOL;
        end else begin
            if (rate_write && rate_arg <= RATE_38400) begin
                next_q.serial_rate_select = rate_arg;
            end
            if (flow_write) begin
                next_q.hw_flow_control_enable = (flow_arg != 8'h00);
            end
            if (eol_write) begin
                next_q.outgoing_eol_select = eol_arg;
            end
        end
        if (serial_settings_query) begin
            next_q.settings_valid = 1'b1;
            next_q.settings_rate  = q.serial_rate_select;
            next_q.settings_eol   = q.outgoing_eol_select;
            next_q.settings_flow  = q.hw_flow_control_enable;
        end

        // Pin synchronisers: a level is taken once stages two and three agree.
        next_q.cts_sync = {q.cts_sync[1:0], cts};
        next_q.cts_ok   = (q.cts_sync[1] == q.cts_sync[2]) ? q.cts_sync[2] : q.cts_ok;
        next_q.rx_sync  = {q.rx_sync[1:0], serial_rx};
        next_q.rx_level = (q.rx_sync[1] == q.rx_sync[2]) ? q.rx_sync[2] : q.rx_level;

        // Request-to-send drops only while flow control is on and the queue is full.
        next_q.rts = !(q.hw_flow_control_enable && rx_queue_full);

        // Transmitter: clear-to-send gates only the start of a character, never its end.
        unique case (q.tx_st)
            TX_IDLE: begin
                if (q.eol_left != EOL_NONE && go) begin
                    next_q.tx_st    = TX_FRAME;
                    next_q.tx_shift = {1'b1, eol_char(q.outgoing_eol_select, q.eol_left), 1'b0};
                    next_q.eol_left = 2'(q.eol_left - 2'h1);
                end else if (tx_valid && q.tx_ready) begin
                    next_q.tx_st    = TX_FRAME;
                    next_q.tx_shift = {1'b1, tx_data, 1'b0};
                    if (tx_last) begin
                        next_q.eol_left = q.outgoing_eol_select[1] ? EOL_PAIR : EOL_SINGLE;
                    end
                end
                if (next_q.tx_st == TX_FRAME) begin
                    next_q.tx_bit    = START_BIT;
                    next_q.tx_cnt    = DIV_W'(div - 1'b1);
                    next_q.serial_tx = 1'b0;
                end
            end
            TX_FRAME: begin
                if (q.tx_cnt != '0) begin
                    next_q.tx_cnt = DIV_W'(q.tx_cnt - 1'b1);
                end else if (q.tx_bit == STOP_BIT) begin
                    next_q.tx_st     = TX_IDLE;
                    next_q.serial_tx = 1'b1;
                end else begin
                    next_q.tx_cnt    = DIV_W'(div - 1'b1);
                    next_q.tx_bit    = 4'(q.tx_bit + 4'h1);
                    next_q.tx_shift  = {1'b1, q.tx_shift[9:1]};
                    next_q.serial_tx = q.tx_shift[1];
                end
            end
        endcase
        // Ready looks at the next clear-to-send so a taken byte never starts blocked.
        next_q.tx_ready = (next_q.tx_st == TX_IDLE) && (next_q.eol_left == EOL_NONE)
                          && (next_q.cts_ok || !next_q.hw_flow_control_enable);

        // Receiver, sampling mid-bit; the far sender must pause while request-to-send is low.
        unique case (q.rx_st)
            RX_IDLE: begin
                if (!q.rx_level) begin
                    next_q.rx_st  = RX_FRAME;
                    next_q.rx_cnt = div >> 1;
                    next_q.rx_bit = START_BIT;
                end
            end
            RX_FRAME: begin
                if (q.rx_cnt != '0) begin
                    next_q.rx_cnt = DIV_W'(q.rx_cnt - 1'b1);
                end else begin
                    next_q.rx_cnt = DIV_W'(div - 1'b1);
                    next_q.rx_bit = 4'(q.rx_bit + 4'h1);
                    if (q.rx_bit == START_BIT && q.rx_level) begin
                        next_q.rx_st = RX_IDLE; // False start: a glitch, not a frame.
                    end else if (q.rx_bit != START_BIT && q.rx_bit != STOP_BIT) begin
                        next_q.rx_shift = {q.rx_level, q.rx_shift[7:1]};
                    end else if (q.rx_bit == STOP_BIT) begin
                        next_q.rx_st = RX_IDLE;
                        if (q.rx_level) begin
                            if ((q.last_term == TERM_CR && is_lf)
                                || (q.last_term == TERM_LF && is_cr)) begin
                                next_q.last_term = TERM_NONE;
                            end else begin
                                next_q.rx_valid  = 1'b1;
                                next_q.rx_data   = q.rx_shift;
                                next_q.rx_eom    = is_cr || is_lf;
                                next_q.last_term = is_cr ? TERM_CR : (is_lf ? TERM_LF : TERM_NONE);
                            end
                        end
                    end
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            q <= RESET_STATE;
        end else if (clk_en) begin
            q <= next_q;
        end
    end

    assign settings_valid = q.settings_valid;
    assign settings_rate  = q.settings_rate;
    assign settings_eol   = q.settings_eol;
    assign settings_flow  = q.settings_flow;
    assign tx_ready       = q.tx_ready;
    assign rx_data        = q.rx_data;
    assign rx_valid       = q.rx_valid;
    assign rx_eom         = q.rx_eom;
    assign serial_tx      = q.serial_tx;
    assign rts            = q.rts;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    rts_block_a:
    assert property (clk_en && q.hw_flow_control_enable && rx_queue_full |=> !rts)
        else $error("request-to-send high while queue full");
    rts_resume_a:
    assert property (clk_en && !rx_queue_full && $past(rx_queue_full) |=> rts)
        else $error("request-to-send not restored after queue drained");
    rts_off_a:
    assert property (clk_en && !q.hw_flow_control_enable |=> rts)
        else $error("request-to-send low with flow control off");
    preset_a:
    assert property (clk_en && serial_defaults_restore |=> q.serial_rate_select == RATE_9600
                     && q.hw_flow_control_enable && q.outgoing_eol_select == EOL_LF)
        else $error("preset did not restore defaults");
    rate_set_a:
    assert property (clk_en && rate_write && rate_arg <= RATE_38400 && !serial_defaults_restore
                     |=> q.serial_rate_select == $past(rate_arg))
        else $error("rate write not taken");
    tx_cts_gate_a:
    assert property (q.tx_st == TX_FRAME && $past(q.tx_st) == TX_IDLE
                     |-> $past(q.cts_ok || !q.hw_flow_control_enable))
        else $error("character started while clear-to-send deasserted");
    frame_bits_a:
    assert property (q.tx_st == TX_FRAME |-> (q.tx_bit == START_BIT && !serial_tx)
                     || (q.tx_bit == STOP_BIT && serial_tx)
                     || (q.tx_bit != START_BIT && q.tx_bit != STOP_BIT))
        else $error("start or stop bit at wrong level");
    eol_tail_a:
    assert property (clk_en && tx_valid && tx_ready && tx_last |=> q.eol_left != EOL_NONE
                     ##1 !tx_ready)
        else $error("no terminator queued after last character");
    rx_term_a:
    assert property (rx_valid |-> rx_eom == (rx_data == CHAR_CR || rx_data == CHAR_LF))
        else $error("terminator not flagged as end of message");
    query_a:
    assert property (clk_en && serial_settings_query |=> settings_valid
                     && settings_rate == $past(q.serial_rate_select)
                     && settings_eol == $past(q.outgoing_eol_select)
                     && settings_flow == $past(q.hw_flow_control_enable))
        else $error("settings answer wrong");
endmodule : serial_port_flow_terminator

// ---- testbench/serial_host_model.sv ----
// Host at the far end of the serial cable: decodes characters from the port
// and sends characters back. Assumes 8N1 framing and the bench clock.
`timescale 1ns/100ps
module serial_host_model (
    // Clock and bit time in clock cycles.
    input  wire logic        ref_clk,
    input  wire logic [15:0] bit_cycles,
    // Serial pins.
    input  wire logic        serial_tx,
    output logic             serial_rx,
    input  wire logic        rts,
    output logic             cts,
    // Bench control and decoded characters, stop bit on top.
    input  wire logic        cts_level,
    output logic       [8:0] got_byte,
    output logic             got_valid,
    output logic             stalled
);
    logic [8:0] shift;

    assign cts = cts_level;

    initial begin
        serial_rx = 1'b1;
        got_valid = 1'b0;
        got_byte  = '0;
        stalled   = 1'b0;
        shift     = '0;
    end

    // Samples at mid-bit; the stop bit is reported so a short frame shows up.
    always begin
        @(negedge serial_tx);
        repeat (bit_cycles / 2) @(posedge ref_clk);
        for (int i = 0; i < 9; i++) begin
            repeat (bit_cycles) @(posedge ref_clk);
            shift = {serial_tx, shift[8:1]};
        end
        got_byte  <= shift;
        got_valid <= 1'b1;
        @(posedge ref_clk);
        got_valid <= 1'b0;
    end

    // The line stays high between frames.
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] frame;
        frame = {1'b1, b, 1'b0};
        for (int w = 0; w < 20000 && rts !== 1'b1; w++) @(posedge ref_clk);
        stalled = (rts !== 1'b1);
        @(posedge ref_clk);
        for (int i = 0; i < 10; i++) begin
            #1 serial_rx = frame[i];
            repeat (bit_cycles) @(posedge ref_clk);
        end
    endtask : send_byte

endmodule : serial_host_model

// ---- testbench/serial_port_flow_terminator_tb.sv ----
// Self-checking bench for the serial port: settings, terminators, flow control.
// Assumes the host model is compiled first; the bit time is shortened by CLK_HZ.
`timescale 1ns/100ps
`define CHK(got, exp) begin \
    n_compared++; \
    if ((got) !== (exp)) begin \
        n_fail++; \
        $display("unexpected at %0t: got %h expected %h", $time, got, exp); \
    end \
end
module serial_port_flow_terminator_tb;
    import serial_port_pkg::*;
    localparam int CLK_HZ = 1_200_000;
    logic        ref_clk, reset_n, rate_write, flow_write, eol_write, serial_defaults_restore;
    logic        serial_settings_query, tx_valid, tx_last, rx_queue_full, cts_level, clk_en;
    logic        settings_valid, settings_flow, tx_ready, rx_valid, rx_eom;
    logic        serial_tx, serial_rx, rts, cts, got_valid, stalled;
    logic [2:0]  rate_arg, settings_rate, exp_rate;
    logic [1:0]  eol_arg, settings_eol;
    logic [7:0]  flow_arg, tx_data, rx_data, b, prev;
    logic [8:0]  got_byte, tx_q[$], rx_q[$];
    logic [5:0]  set_q[$];
    logic [15:0] bit_cycles;
    logic [31:0] seed;
    logic [7:0]  seq[9] = '{8'h00, 8'h0D, 8'h0A, 8'h00, 8'h0A, 8'h0D, 8'h00, 8'h0D, 8'h0D};
    int          n_fail, n_compared;

    serial_port_flow_terminator #(.CLK_HZ(CLK_HZ)) u_dut (.ref_clk, .reset_n, .clk_en,
        .rate_write, .rate_arg, .flow_write, .flow_arg, .eol_write, .eol_arg,
        .serial_defaults_restore, .serial_settings_query, .settings_valid, .settings_rate,
        .settings_eol, .settings_flow, .tx_data, .tx_valid, .tx_last, .tx_ready, .rx_data,
        .rx_valid, .rx_eom, .rx_queue_full, .serial_tx, .serial_rx, .rts, .cts);
    serial_host_model u_host (.ref_clk, .bit_cycles, .serial_tx, .serial_rx, .rts, .cts,
        .cts_level, .got_byte, .got_valid, .stalled);

    always #5 ref_clk = ~ref_clk;

    function automatic logic [7:0] next_byte();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction : next_byte

    task automatic wrap_up();
        if (n_fail == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : wrap_up

    // Strobes are {rate, flow, eol, restore, query}; all share one argument.
    task automatic setting(input logic [4:0] strobes, input logic [7:0] arg);
        @(posedge ref_clk);
        #1;
        rate_arg = arg[2:0];
        flow_arg = arg;
        eol_arg = arg[1:0];
        {rate_write, flow_write, eol_write, serial_defaults_restore, serial_settings_query} = strobes;
        @(posedge ref_clk);
        #1;
        {rate_write, flow_write, eol_write, serial_defaults_restore, serial_settings_query} = '0;
    endtask : setting

    task automatic ask(input logic [2:0] r, input logic [1:0] e, input logic f);
        set_q.push_back({r, e, f});
        setting(5'b00001, 8'h00);
    endtask : ask

    task automatic send_tx(input logic [7:0] d, input logic last, input logic [1:0] eol);
        int w;
        tx_q.push_back({1'b1, d});
        if (last) tx_q.push_back({1'b1, eol[0] ? 8'h0A : 8'h0D});
        if (last && eol[1]) tx_q.push_back({1'b1, eol[0] ? 8'h0D : 8'h0A});
        @(posedge ref_clk);
        #1;
        tx_data = d;
        tx_last = last;
        tx_valid = 1'b1;
        for (w = 0; w < 30000; w++) begin
            @(posedge ref_clk);
            if (tx_ready === 1'b1) break;
        end
        #1;
        tx_valid = 1'b0;
        if (w == 30000) begin
            n_fail++;
            wrap_up();
        end
    endtask : send_tx

    // Waits for all notes to be matched, then long enough for a stray character.
    task automatic drain();
        int w;
        for (w = 0; w < 20000; w++) begin
            @(posedge ref_clk);
            if (tx_q.size() + rx_q.size() + set_q.size() == 0) break;
        end
        if (w == 20000 || stalled === 1'b1) begin
            n_fail++;
            wrap_up();
        end
        repeat (12 * bit_cycles) @(posedge ref_clk);
    endtask : drain

    always @(posedge ref_clk) begin
        logic [8:0] e;
        if (got_valid === 1'b1) begin
            e = tx_q.size() ? tx_q.pop_front() : 'x;
            `CHK(got_byte, e)
        end
        if (rx_valid === 1'b1) begin
            e = rx_q.size() ? rx_q.pop_front() : 'x;
            `CHK({rx_eom, rx_data}, e)
        end
        if (settings_valid === 1'b1) begin
            e = set_q.size() ? {3'h0, set_q.pop_front()} : 'x;
            `CHK({3'h0, settings_rate, settings_eol, settings_flow}, e)
        end
    end

    initial begin
        repeat (100000) @(posedge ref_clk);
        n_fail++;
        wrap_up();
    end

    initial begin
        {ref_clk, reset_n, rate_write, flow_write, eol_write, serial_defaults_restore} = '0;
        {serial_settings_query, tx_valid, tx_last, rx_queue_full} = '0;
        {rate_arg, flow_arg, eol_arg, tx_data} = '0;
        cts_level = 1'b1;
        clk_en = 1'b1;
        n_fail = 0;
        n_compared = 0;
        seed = 32'hB468;
        bit_cycles = 16'(CLK_HZ / BAUD_9600);
        repeat (5) @(posedge ref_clk);
        #1 reset_n = 1'b1;
        repeat (4) @(posedge ref_clk);
        `CHK(rts, 1'b1)
        ask(RATE_9600, EOL_LF, 1'b1);
        send_tx(next_byte(), 1'b1, EOL_LF);
        drain();
        for (int r = 0; r < 8; r++) begin
            setting(5'b10000, 8'(r));
            if (r < 6) exp_rate = 3'(r);
            ask(exp_rate, EOL_LF, 1'b1);
        end
        bit_cycles = 16'(CLK_HZ / BAUD_38400);
        for (int e = 0; e < 4; e++) begin
            setting(5'b00100, 8'(e));
            send_tx(next_byte(), 1'b0, 2'(e));
            send_tx(next_byte(), 1'b1, 2'(e));
            ask(RATE_38400, 2'(e), 1'b1);
            drain();
        end
        // Clear-to-send low holds the next character back.
        #1 cts_level = 1'b0;
        repeat (6) @(posedge ref_clk);
        fork
            send_tx(8'hA5, 1'b1, LF_THEN_CR_TERMINATOR);
            begin
                repeat (200) begin
                    @(posedge ref_clk);
                    `CHK({serial_tx, tx_ready}, 2'b10)
                end
                #1 cts_level = 1'b1;
            end
        join
        drain();
        setting(5'b01000, 8'h00);
        #1 cts_level = 1'b0;
        repeat (6) @(posedge ref_clk);
        send_tx(next_byte(), 1'b1, LF_THEN_CR_TERMINATOR);
        drain();
        #1 rx_queue_full = 1'b1;
        repeat (20) begin
            @(posedge ref_clk);
            `CHK(rts, 1'b1)
        end
        ask(RATE_38400, LF_THEN_CR_TERMINATOR, 1'b0);
        setting(5'b01000, next_byte() | 8'h01);
        cts_level = 1'b1;
        repeat (2) @(posedge ref_clk);
        `CHK(rts, 1'b0)
        ask(RATE_38400, LF_THEN_CR_TERMINATOR, 1'b1);
        b = next_byte() | 8'h10;
        rx_q.push_back({1'b0, b});
        fork
            u_host.send_byte(b);
            begin
                repeat (400) begin
                    @(posedge ref_clk);
                    `CHK(rts, 1'b0)
                end
                `CHK(rx_q.size(), 1)
                #1 rx_queue_full = 1'b0;
                repeat (2) @(posedge ref_clk);
                `CHK(rts, 1'b1)
            end
        join
        drain();
        prev = 8'h00;
        foreach (seq[i]) begin
            b = (seq[i] == 8'h00) ? (next_byte() | 8'h10) : seq[i];
            if (!((b == 8'h0A && prev == 8'h0D) || (b == 8'h0D && prev == 8'h0A)))
                rx_q.push_back({b == 8'h0D || b == 8'h0A, b});
            u_host.send_byte(b);
            prev = b;
        end
        drain();
        // With the clock enable low a rate write and a query must both be ignored.
        #1 clk_en = 1'b0;
        setting(5'b10001, 8'h00);
        clk_en = 1'b1;
        ask(RATE_38400, LF_THEN_CR_TERMINATOR, 1'b1);
        setting(5'b11100, 8'h00);
        ask(RATE_1200, EOL_CR, 1'b0);
        setting(5'b11110, 8'h00);
        ask(RATE_9600, EOL_LF, 1'b1);
        bit_cycles = 16'(CLK_HZ / BAUD_9600);
        send_tx(next_byte(), 1'b1, EOL_LF);
        drain();
        wrap_up();
    end

endmodule : serial_port_flow_terminator_tb
